// >>> floppy_board_port_decode.sv
// Bus-side port decode, strobes, readback, clock, head-load timer and interrupt logic.
`include "floppy_port_defines.svh"

// Operation
// - Answer five ports, jumper picks 63-67 or E3-E7.
// - Read strobe low on input, write on output.
// - Ports X5-X7 read back what was written.
// - Port X3 bits 0-4 read back.
// - Head load gives 35 ms low pulse.
// - Controller gets a 4 MHz clock.
// - Join interrupt priority chain in and out.
// - Jumper picks one of four interrupt modes.
// - Insert wait states to pace sector data.
module floppy_board_port_decode #(
   parameter int HEAD_LOAD_CYCLES = `FBP_HEAD_LOAD_MS * `FBP_CLK_KHZ,
   parameter logic [7:0] RESTART_OPCODE = 8'hEF,
   parameter logic [7:0] VECTOR_BYTE = 8'h40
) (
   input wire logic mclk_i,
   input wire logic reset_n_i,
   input wire logic base_high_i,
   input wire floppy_port_pkg::int_mode_t int_mode_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] data_out_i,
   input wire logic sinp_i,
   input wire logic sout_i,
   input wire logic pdbin_i,
   input wire logic pwr_n_i,
   input wire logic sinta_i,
   input wire logic priority_chain_in_i,
   input wire logic [7:0] ctl_data_i,
   input wire logic ctl_drq_i,
   input wire logic ctl_intrq_i,
   input wire logic ctl_head_load_i,
   input wire logic [2:0] sense_i,
   output logic [7:0] data_in_o,
   output logic data_in_en_o,
   output logic prdy_o,
   output logic int_n_o,
   output logic vi2_n_o,
   output logic priority_chain_out_o,
   output logic controller_read_strobe_n_o,
   output logic ctl_write_strobe_n_o,
   output logic [1:0] ctl_addr_o,
   output logic [7:0] ctl_data_o,
   output logic ctl_clk_en_o,
   output logic [7:0] select_o,
   output logic head_load_timer_n_o
);
   import floppy_port_pkg::*;

   localparam int CTL_DIV = `FBP_CTL_CLK_KHZ > 0 ? `FBP_CLK_KHZ / `FBP_CTL_CLK_KHZ : 1;
   localparam int HL_W = 22;
   localparam int CTL_GAP = CTL_DIV - 1;

   // A zero pulse never shows; a longer one or a slower divide overflows its counter.
   if (HEAD_LOAD_CYCLES < 1 || HEAD_LOAD_CYCLES >= (1 << HL_W) || CTL_DIV < 2 || CTL_DIV > 32)
   begin : g_bad_setting
      $error("head-load or divider setting out of range");
   end

   logic [3:0] base_nib;
   logic [3:0] ofs;
   logic hit;
   logic ctl_port;
   logic host_rd;
   logic host_wr;
   logic int_on;
   logic int_req;
   logic ack_drive;
   logic wait_cond;

   // Port decode is qualified by a live port cycle so stray addresses never select.
   always_comb
   begin
      base_nib = base_high_i ? `FBP_BASE_HIGH : `FBP_BASE_LOW;
      ofs = addr_i[3:0];
      hit = (addr_i[7:4] == base_nib) && (ofs >= `FBP_OFS_SELECT)
            && (ofs <= `FBP_OFS_DATA) && (sinp_i || sout_i) && !sinta_i;
      ctl_port = hit && (ofs != `FBP_OFS_SELECT);
      host_rd = hit && sinp_i && pdbin_i;
      host_wr = hit && sout_i && !pwr_n_i;
   end

   // Interrupt request goes out only with the chain enabled from above.
   always_comb
   begin
      int_on = (int_mode_i != INT_NONE);
      int_req = int_on && ctl_intrq_i && priority_chain_in_i;
      int_n_o = !(int_req && (int_mode_i == INT_RESTART || int_mode_i == INT_VECTOR));
      vi2_n_o = !(int_req && int_mode_i == INT_EXTERNAL);
      priority_chain_out_o = priority_chain_in_i && !(int_on && ctl_intrq_i);
      ack_drive = sinta_i && pdbin_i && int_req
                  && (int_mode_i == INT_RESTART || int_mode_i == INT_VECTOR);
   end

   logic [7:0] select_reg, select_next;
   logic [7:0] data_in_reg, data_in_next;
   logic data_en_reg, data_en_next;
   logic rd_n_reg, rd_n_next;
   logic wr_n_reg, wr_n_next;
   logic [1:0] caddr_reg, caddr_next;
   logic [7:0] cdata_reg, cdata_next;

   // Bus and controller side registers; data comes from flops, one cycle behind the bus.
   always_comb
   begin
      select_next = select_reg;
      if (host_wr && ofs == `FBP_OFS_SELECT)
         select_next = data_out_i;
      rd_n_next = !(ctl_port && sinp_i && pdbin_i);
      wr_n_next = !(ctl_port && sout_i && !pwr_n_i);
      caddr_next = ctl_port ? 2'(ofs - `FBP_OFS_CMD_STATUS) : caddr_reg;
      cdata_next = data_out_i;
      data_en_next = host_rd || ack_drive;
      data_in_next = data_in_reg;
      if (ack_drive)
         data_in_next = (int_mode_i == INT_RESTART) ? RESTART_OPCODE : VECTOR_BYTE;
      else if (host_rd && ofs == `FBP_OFS_SELECT)
         data_in_next = {sense_i, select_reg[`FBP_SEL_RB_MSB:0]};
      else if (host_rd)
         data_in_next = ctl_data_i;
   end

   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         select_reg <= `FBP_SEL_RESET;
         data_in_reg <= `FBP_DATA_RESET;
         data_en_reg <= 1'b0;
         rd_n_reg <= 1'b1;
         wr_n_reg <= 1'b1;
         caddr_reg <= 2'h0;
         cdata_reg <= `FBP_DATA_RESET;
      end
      else
      begin
         select_reg <= select_next;
         data_in_reg <= data_in_next;
         data_en_reg <= data_en_next;
         rd_n_reg <= rd_n_next;
         wr_n_reg <= wr_n_next;
         caddr_reg <= caddr_next;
         cdata_reg <= cdata_next;
      end
   end

   assign select_o = select_reg;
   assign data_in_o = data_in_reg;
   assign data_in_en_o = data_en_reg;
   assign controller_read_strobe_n_o = rd_n_reg;
   assign ctl_write_strobe_n_o = wr_n_reg;
   assign ctl_addr_o = caddr_reg;
   assign ctl_data_o = cdata_reg;

   // Hold the host on the data port until the controller has a byte or is done.
   always_comb
   begin
      wait_cond = select_reg[`FBP_SEL_WAIT_BIT] && hit && ofs == `FBP_OFS_DATA
                  && !ctl_drq_i && !ctl_intrq_i;
      prdy_o = !wait_cond;
   end

   logic [4:0] div_reg, div_next;
   logic [HL_W-1:0] hl_cnt_reg, hl_cnt_next;
   logic hl_prev_reg, hl_prev_next;

   // Controller clock enable and a retriggerable head-load timer.
   always_comb
   begin
      div_next = (div_reg == 5'(CTL_DIV - 1)) ? 5'h00 : div_reg + 5'h01;
      hl_prev_next = ctl_head_load_i;
      hl_cnt_next = hl_cnt_reg;
      if (ctl_head_load_i && !hl_prev_reg)
         hl_cnt_next = HL_W'(HEAD_LOAD_CYCLES);
      else if (hl_cnt_reg != '0)
         hl_cnt_next = hl_cnt_reg - 1'b1;
   end

   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         div_reg <= 5'h00;
         hl_cnt_reg <= '0;
         hl_prev_reg <= 1'b0;
      end
      else
      begin
         div_reg <= div_next;
         hl_cnt_reg <= hl_cnt_next;
         hl_prev_reg <= hl_prev_next;
      end
   end

   assign ctl_clk_en_o = (div_reg == 5'(CTL_DIV - 1));
   assign head_load_timer_n_o = (hl_cnt_reg == '0);

   // Helper: length of the current head-load low pulse.
   logic [HL_W-1:0] low_len;
   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         low_len <= '0;
      else if (ctl_head_load_i && !hl_prev_reg)
         low_len <= '0;
      else if (!head_load_timer_n_o)
         low_len <= low_len + 1'b1;
   end

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!reset_n_i);

   property p_decode_range;
      !controller_read_strobe_n_o |-> $past(addr_i[7:4]) == (base_high_i ? 4'hE : 4'h6);
   endproperty
   a_decode_range: assert property (p_decode_range) else $error("strobe outside port range");

   property p_read_strobe;
      (ctl_port && sinp_i && pdbin_i) |=> !controller_read_strobe_n_o && ctl_write_strobe_n_o;
   endproperty
   a_read_strobe: assert property (p_read_strobe) else $error("read strobe missing");

   property p_write_strobe;
      (ctl_port && sout_i && !pwr_n_i)
         |=> !ctl_write_strobe_n_o && ctl_data_o == $past(data_out_i);
   endproperty
   a_write_strobe: assert property (p_write_strobe) else $error("write strobe missing");

   property p_reg_readback;
      (host_rd && ofs != 4'h3) |=> data_in_o == $past(ctl_data_i) && data_in_en_o;
   endproperty
   a_reg_readback: assert property (p_reg_readback) else $error("register readback wrong");

   property p_select_readback;
      (host_wr && ofs == 4'h3) ##1 (host_rd && ofs == 4'h3)
         |=> data_in_o[4:0] == $past(data_out_i[4:0], 2);
   endproperty
   a_select_readback: assert property (p_select_readback) else $error("bad select readback");

   property p_head_load_length;
      $rose(head_load_timer_n_o) |-> low_len == HL_W'(HEAD_LOAD_CYCLES);
   endproperty
   a_head_load_length: assert property (p_head_load_length) else $error("bad pulse length");

   property p_head_load_start;
      (ctl_head_load_i && !hl_prev_reg) |=> !head_load_timer_n_o [*1];
   endproperty
   a_head_load_start: assert property (p_head_load_start) else $error("pulse did not start");

   property p_ctl_clock;
      ctl_clk_en_o |=> !ctl_clk_en_o ##CTL_GAP ctl_clk_en_o;
   endproperty
   a_ctl_clock: assert property (p_ctl_clock) else $error("controller clock period wrong");

   property p_chain;
      (!priority_chain_in_i || (int_mode_i != INT_NONE && ctl_intrq_i)) |-> !priority_chain_out_o;
   endproperty
   a_chain: assert property (p_chain) else $error("priority chain passed through");

   property p_int_mode;
      (int_mode_i == INT_NONE) |-> int_n_o && vi2_n_o && !ack_drive;
   endproperty
   a_int_mode: assert property (p_int_mode) else $error("interrupt while disabled");

   property p_undriven;
      !(host_rd || ack_drive) |=> !data_in_en_o;
   endproperty
   a_undriven: assert property (p_undriven) else $error("data bus driven without select");

   property p_wait;
      (select_reg[5] && hit && ofs == 4'h7 && !ctl_drq_i && !ctl_intrq_i) |-> !prdy_o;
   endproperty
   a_wait: assert property (p_wait) else $error("no wait state on data port");

   c_read: cover property (host_rd && ofs == 4'h7);
   c_write: cover property (host_wr && ofs == 4'h3);
   c_head_load: cover property ($rose(head_load_timer_n_o));
   c_ack: cover property (ack_drive ##1 data_in_en_o);

endmodule

// >>> floppy_board_port_decode_tb.sv
// Self-checking bench for the floppy board port decode.
module floppy_board_port_decode_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import floppy_port_pkg::*;
   localparam int HL = 20;
   localparam logic [7:0] RST_OP = 8'hEF;
   localparam logic [7:0] VEC = 8'h40;
   localparam logic [7:0] IRQ_EXP [4] = '{8'h07, 8'h02, 8'h04, 8'h02};
   logic mclk_i = 0, reset_n_i = 0, base_high_i = 0, drq = 0, intrq = 0, hload = 0;
   int_mode_t mode = INT_NONE;
   logic [7:0] addr, dout, din, cdout, sel;
   logic [7:0] regs [4] = '{8'h00, 8'h00, 8'h00, 8'h00};
   logic sinp, sout, pdbin, pwr_n, sinta, chain, din_en, prdy, int_n, vi2_n, chain_out;
   logic rd_n, wr_n, clk_en, hl_n;
   logic [1:0] caddr;
   logic [2:0] sense = 3'h5;
   int error_cnt = 0, samples_checked = 0;
   floppy_board_port_decode #(.HEAD_LOAD_CYCLES(HL), .RESTART_OPCODE(RST_OP),
      .VECTOR_BYTE(VEC)) dut_u (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
      .base_high_i(base_high_i), .int_mode_i(mode), .addr_i(addr), .data_out_i(dout),
      .sinp_i(sinp), .sout_i(sout), .pdbin_i(pdbin), .pwr_n_i(pwr_n), .sinta_i(sinta),
      .priority_chain_in_i(chain), .ctl_data_i(regs[caddr]), .ctl_drq_i(drq),
      .ctl_intrq_i(intrq), .ctl_head_load_i(hload), .sense_i(sense), .data_in_o(din),
      .data_in_en_o(din_en), .prdy_o(prdy), .int_n_o(int_n), .vi2_n_o(vi2_n),
      .priority_chain_out_o(chain_out), .controller_read_strobe_n_o(rd_n),
      .ctl_write_strobe_n_o(wr_n), .ctl_addr_o(caddr), .ctl_data_o(cdout),
      .ctl_clk_en_o(clk_en), .select_o(sel), .head_load_timer_n_o(hl_n));
   host_bus_model host_u (.mclk_i(mclk_i), .addr_o(addr), .dout_o(dout), .sinp_o(sinp),
      .sout_o(sout), .pdbin_o(pdbin), .pwr_n_o(pwr_n), .sinta_o(sinta), .chain_o(chain));
   // Free-running system clock.
   initial
   begin
      forever #5 mclk_i = ~mclk_i;
   end
   // Controller register file: it latches on the write strobe, so readback
   // proves both the strobe and the forwarded write data.
   always @(posedge mclk_i)
      if (wr_n === 1'b0)
         regs[caddr] <= cdout;
   // Compare one value against its expectation and count a mismatch.
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Ports X5-X7 round trip, then addresses just outside the range and the same port at the other base.
   task automatic t_regs(input logic hi);
      logic [7:0] b;
      logic [7:0] miss [3];
      @(negedge mclk_i);
      base_high_i = hi;
      b = hi ? 8'hE0 : 8'h60;
      miss = '{8'(b + 2), 8'(b + 8), 8'((b ^ 8'h80) + 5)};
      for (int i = 5; i < 8; i++)
      begin
         host_u.io(1'b1, 1'b0, 8'(b + i), {hi, 7'(8'h30 + i)}, 2);
         check({7'h0, wr_n}, 8'h00);
         host_u.idle();
         host_u.io(1'b0, 1'b0, 8'(b + i), 8'h00, 3);
         check({6'h0, rd_n, din_en}, 8'h01);
         check(din, {hi, 7'(8'h30 + i)});
         host_u.idle();
      end
      foreach (miss[k])
      begin
         host_u.io(1'b0, 1'b0, miss[k], 8'h00, 3);
         check({6'h0, rd_n, din_en}, 8'h02);
         host_u.idle();
      end
   endtask
   // Select port keeps all eight bits, reads back bits 4:0 and returns the sense lines above them.
   // The read follows the write back to back, as the bus allows.
   task automatic t_select();
      host_u.io(1'b1, 1'b0, 8'h63, 8'h95, 2);
      host_u.io(1'b0, 1'b0, 8'h63, 8'h00, 3);
      check(sel, 8'h95);
      check(din, {sense, 5'h15});
      host_u.idle();
   endtask
   // Mid-run reset returns select, both strobes, data enable and the head-load output to their idle values.
   task automatic t_reset();
      @(negedge mclk_i);
      reset_n_i = 1'b0;
      #1 check(sel, 8'h00);
      check({4'h0, rd_n, wr_n, din_en, hl_n}, 8'h0D);
      @(negedge mclk_i);
      reset_n_i = 1'b1;
   endtask
   // With waits enabled a data port read stalls until the controller asks.
   task automatic t_wait();
      host_u.io(1'b1, 1'b0, 8'h63, 8'h20, 2);
      host_u.idle();
      host_u.io(1'b0, 1'b0, 8'h67, 8'h00, 1);
      check({7'h0, prdy}, 8'h00);
      @(negedge mclk_i);
      drq = 1'b1;
      #1 check({7'h0, prdy}, 8'h01);
      host_u.idle();
      drq = 1'b0;
      host_u.io(1'b1, 1'b0, 8'h63, 8'h00, 2);
      host_u.idle();
   endtask
   // Head-load pulse width and controller clock rate, counted per cycle.
   task automatic t_timers();
      int n = 0;
      int p = 0;
      @(negedge mclk_i);
      hload = 1'b1;
      repeat (2 * HL) @(negedge mclk_i) n += (hl_n === 1'b0);
      check(8'(n), 8'(HL));
      hload = 1'b0;
      repeat (100) @(negedge mclk_i) p += (clk_en === 1'b1);
      check(8'(p), 8'h04);
   endtask
   // Every interrupt mode, its request line, chain output and acknowledge byte.
   task automatic t_irq();
      for (int m = 0; m < 4; m++)
      begin
         @(negedge mclk_i);
         mode = int_mode_t'(m);
         intrq = 1'b1;
         #1 check({5'h0, int_n, vi2_n, chain_out}, IRQ_EXP[m]);
         if (m == 1 || m == 3)
         begin
            host_u.io(1'b0, 1'b1, 8'hFF, 8'h00, 2);
            check(din, (m == 1) ? RST_OP : VEC);
            host_u.idle();
         end
      end
      host_u.set_chain(1'b0);
      #1 check({6'h0, int_n, chain_out}, 8'h02);
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // Main sequence after two cycles of reset.
   initial
   begin
      repeat (2) @(negedge mclk_i);
      reset_n_i = 1'b1;
      t_regs(1'b0);
      t_regs(1'b1);
      base_high_i = 1'b0;
      t_select();
      t_reset();
      t_wait();
      t_timers();
      t_irq();
      conclude();
   end
   // Watchdog, well past the few hundred cycles the tests need.
   initial
   begin
      #200000;
      error_cnt++;
      conclude();
   end
endmodule

// >>> floppy_port_defines.svh
// Address map, field positions, reset values and timing figures for the floppy board port.
`ifndef FLOPPY_PORT_DEFINES_SVH
`define FLOPPY_PORT_DEFINES_SVH

// High nibble of the port range for each setting of the base jumper.
`define FBP_BASE_LOW 4'h6
`define FBP_BASE_HIGH 4'hE

// Low nibble of each of the five ports.
`define FBP_OFS_SELECT 4'h3
`define FBP_OFS_CMD_STATUS 4'h4
`define FBP_OFS_TRACK 4'h5
`define FBP_OFS_SECTOR 4'h6
`define FBP_OFS_DATA 4'h7

// Select port layout: readback bits, wait enable bit and reset value.
`define FBP_SEL_RB_MSB 4
`define FBP_SEL_WAIT_BIT 5
`define FBP_SEL_RESET 8'h00

// Reset value of the bus-facing data register.
`define FBP_DATA_RESET 8'h00

// Timing: system clock, controller clock and head-load pulse.
`define FBP_CLK_KHZ 100000
`define FBP_CTL_CLK_KHZ 4000
`define FBP_HEAD_LOAD_MS 35

`endif

// >>> floppy_port_pkg.sv
// Types shared by the floppy board port logic.
package floppy_port_pkg;

   // Interrupt handling chosen by jumper.
   typedef enum logic [1:0] {
      INT_NONE,
      INT_RESTART,
      INT_EXTERNAL,
      INT_VECTOR
   } int_mode_t;

endpackage

// >>> host_bus_model.sv
// Bus host model that runs port cycles against the floppy board port.
module host_bus_model (
   input wire logic mclk_i,
   output logic [7:0] addr_o,
   output logic [7:0] dout_o,
   output logic sinp_o,
   output logic sout_o,
   output logic pdbin_o,
   output logic pwr_n_o,
   output logic sinta_o,
   output logic chain_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // Idle bus; the chain enable starts high so this board has top priority until set_chain drops it.
   initial
   begin
      {addr_o, dout_o, sinp_o, sout_o, pdbin_o, sinta_o} = '0;
      pwr_n_o = 1'b1;
      chain_o = 1'b1;
   end
   // Start a port or acknowledge cycle and hold it for n rising edges.
   task automatic io(input logic wr, input logic ack, input logic [7:0] a,
                     input logic [7:0] d, input int n);
      @(negedge mclk_i);
      addr_o = a;
      dout_o = d;
      sout_o = wr;
      pwr_n_o = !wr;
      sinp_o = !wr && !ack;
      sinta_o = ack;
      pdbin_o = !wr;
      repeat (n) @(posedge mclk_i);
      #1;
   endtask
   // End the cycle; released lines show the inverse so stale data never matches.
   task automatic idle();
      @(negedge mclk_i);
      addr_o = ~addr_o;
      dout_o = ~dout_o;
      {sinp_o, sout_o, pdbin_o, sinta_o} = 4'h0;
      pwr_n_o = 1'b1;
   endtask
   // Drop or restore the chain enable from above, at a falling edge like every other line.
   task automatic set_chain(input logic en);
      @(negedge mclk_i);
      chain_o = en;
   endtask
endmodule
